/* verilog/pin_pkg.sv */
// Shared types and constants for the port pin override logic.
// Assumes one clock domain and a sleep controller that reports its mode each cycle.
package pin_pkg;

  // ----------------------------------------------------------------
  // Sizes and positions
  // ----------------------------------------------------------------
  localparam int unsigned PORT_PINS       = 8;
  localparam int unsigned PULL_UP_OFF_BIT = 4;
  localparam int unsigned RESET_STAGES    = 2;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SLEEP_ACTIVE,
    SLEEP_IDLE,
    SLEEP_ADC_NOISE,
    SLEEP_POWER_DOWN,
    SLEEP_POWER_SAVE,
    SLEEP_STANDBY,
    SLEEP_EXT_STANDBY
  } sleep_mode_t;

  typedef enum logic [1:0] {
    SENSE_LOW,
    SENSE_ANY,
    SENSE_FALL,
    SENSE_RISE
  } int_sense_t;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pull_up_override_enable;
    logic pull_up_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic value_override_enable;
    logic value_override_value;
    logic toggle_override_enable;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } pin_override_t;

  typedef struct packed {
    logic                 clamp;
    logic [PORT_PINS-1:0] direction_bit;
    logic [PORT_PINS-1:0] output_value_bit;
    logic [PORT_PINS-1:0] drive_en;
    logic [PORT_PINS-1:0] drive_val;
    logic [PORT_PINS-1:0] pull_up;
    logic [PORT_PINS-1:0] input_en;
    logic [PORT_PINS-1:0] pin_prev;
    logic [PORT_PINS-1:0] int_flag;
  } port_state_t;

  localparam port_state_t STATE_RESET = '0;

endpackage

/* verilog/pin_sync.sv */
// Two-stage synchronizer, one pair of flip-flops per bit.
// Assumes the inputs are asynchronous to clk and rst_n is already synchronous on release.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------
  // The first stage feeds only the second stage, so no logic sees a metastable value.
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    logic meta_r;
    logic sync_r;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_r <= 1'b0;
        sync_r <= 1'b0;
      end else begin
        meta_r <= async_in[g];
        sync_r <= meta_r;
      end
    end
    assign sync_out[g] = sync_r;
  end

endmodule // pin_sync
`default_nettype wire

/* verilog/port_pin_override_logic.sv */
// One port of general digital I/O pins merged with alternate-function overrides.
// Assumes peripherals drive the override carriers from sys_clk logic and pads resolve drive.
//
// Contract
// - Input clamp asserts only in power-down, power-save and standby sleep modes.
// - An enabled external interrupt lifts the clamp; a disabled one leaves it.
// - Held-high rising- or any-edge-sensed pin whose input the clamp gated sets its flag on wake from clamping sleep.
// - Software pull-ups stay off while reset is active.
// - Pull-up follows override value when enabled, else on for direction/value/disable 010.
// - Driver enable follows direction override value when enabled, else the direction bit.
// - Driven value is the driver enable ANDed with the value override when enabled, else with the output value bit.
// - Toggle override inverts the stored output value bit.
// - Input enable follows its override value when enabled, else normal or sleep state.
// - Alternate functions get the Schmitt output before the synchronizer, syncing it themselves.
// - Global pull-up off kills every pull-up without an enabled pull-up override, even with direction/value 01.
// - Write strobes shared per port; clock, clamp, pull-up off shared by all ports.
// - Direction one makes an output, zero an input; reset tristates pins immediately.
// - Writing one to a pin input bit toggles that output value bit.
`timescale 1ns/100ps
`default_nettype none
module port_pin_override_logic (
  input  wire logic                                           sys_clk,
  input  wire logic                                           rstn,
  input  wire logic                                           dir_wr,
  input  wire logic                   [pin_pkg::PORT_PINS-1:0] dir_wdata,
  input  wire logic                                           val_wr,
  input  wire logic                   [pin_pkg::PORT_PINS-1:0] val_wdata,
  input  wire logic                                           pin_wr,
  input  wire logic                   [pin_pkg::PORT_PINS-1:0] pin_wdata,
  input  wire logic                                           global_pull_up_off,
  input  wire pin_pkg::sleep_mode_t                           sleep_mode,
  input  wire logic                   [pin_pkg::PORT_PINS-1:0] ext_int_en,
  input  wire pin_pkg::int_sense_t    [pin_pkg::PORT_PINS-1:0] ext_int_sense,
  input  wire logic                   [pin_pkg::PORT_PINS-1:0] ext_int_flag_clr,
  input  wire pin_pkg::pin_override_t [pin_pkg::PORT_PINS-1:0] ovr,
  input  wire logic                   [pin_pkg::PORT_PINS-1:0] pad_in,
  output logic                        [pin_pkg::PORT_PINS-1:0] pad_out,
  output logic                        [pin_pkg::PORT_PINS-1:0] pad_oe,
  output logic                        [pin_pkg::PORT_PINS-1:0] pad_pull_up,
  output logic                        [pin_pkg::PORT_PINS-1:0] schmitt_output_tap,
  output logic                        [pin_pkg::PORT_PINS-1:0] dir_rdata,
  output logic                        [pin_pkg::PORT_PINS-1:0] val_rdata,
  output logic                        [pin_pkg::PORT_PINS-1:0] pin_rdata,
  output logic                        [pin_pkg::PORT_PINS-1:0] ext_int_flag,
  output logic                                                sleep_clamp
);

  localparam int unsigned P = pin_pkg::PORT_PINS;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Assertion is asynchronous so the pads tristate even with no clock running.
  logic [pin_pkg::RESET_STAGES-1:0] rst_sync_r;
  logic                             rst_n_s;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= '0;
    end else begin
      rst_sync_r <= {rst_sync_r[pin_pkg::RESET_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_r[pin_pkg::RESET_STAGES-1];

  // ----------------------------------------------------------------
  // Input path
  // ----------------------------------------------------------------
  pin_pkg::port_state_t st_r;
  pin_pkg::port_state_t st_nxt;
  logic [P-1:0]         pin_sync_q;

  assign schmitt_output_tap = pad_in & st_r.input_en;

  pin_sync #(
    .WIDTH    (P)
  ) u_pin_sync (
    .clk      (sys_clk),
    .rst_n    (rst_n_s),
    .async_in (schmitt_output_tap),
    .sync_out (pin_sync_q)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [P-1:0] toggle;
    logic         cur;
    logic         prev;
    logic         hit;
    toggle = '0;
    cur    = 1'b0;
    prev   = 1'b0;
    hit    = 1'b0;
    st_nxt = st_r;
    st_nxt.clamp = (sleep_mode == pin_pkg::SLEEP_POWER_DOWN) ||
                   (sleep_mode == pin_pkg::SLEEP_POWER_SAVE) ||
                   (sleep_mode == pin_pkg::SLEEP_STANDBY);
    if (dir_wr) begin
      st_nxt.direction_bit = dir_wdata;
    end
    if (val_wr) begin
      st_nxt.output_value_bit = val_wdata;
    end
    if (pin_wr) begin
      toggle = pin_wdata;
    end
    for (int i = 0; i < P; i++) begin
      toggle[i] = toggle[i] | ovr[i].toggle_override_enable;
      if (ovr[i].pull_up_override_enable) begin
        st_nxt.pull_up[i] = ovr[i].pull_up_override_value;
      end else begin
        st_nxt.pull_up[i] = !st_r.direction_bit[i] && st_r.output_value_bit[i] &&
                            !global_pull_up_off;
      end
      if (ovr[i].direction_override_enable) begin
        st_nxt.drive_en[i] = ovr[i].direction_override_value;
      end else begin
        st_nxt.drive_en[i] = st_r.direction_bit[i];
      end
      if (ovr[i].value_override_enable) begin
        st_nxt.drive_val[i] = st_nxt.drive_en[i] & ovr[i].value_override_value;
      end else begin
        st_nxt.drive_val[i] = st_nxt.drive_en[i] & st_r.output_value_bit[i];
      end
      if (ovr[i].input_enable_override_enable) begin
        st_nxt.input_en[i] = ovr[i].input_enable_override_value;
      end else begin
        st_nxt.input_en[i] = !st_r.clamp || ext_int_en[i];
      end
      // The clamp drives the synced input low, so a held-high pin looks like an edge on wake.
      cur  = pin_sync_q[i];
      prev = st_r.pin_prev[i];
      unique case (ext_int_sense[i])
        pin_pkg::SENSE_LOW:  hit = !cur;
        pin_pkg::SENSE_ANY:  hit = cur != prev;
        pin_pkg::SENSE_FALL: hit = prev && !cur;
        pin_pkg::SENSE_RISE: hit = !prev && cur;
      endcase
      // A new event wins over a clear in the same cycle.
      st_nxt.int_flag[i] = hit || (st_r.int_flag[i] && !ext_int_flag_clr[i]);
    end
    st_nxt.pin_prev         = pin_sync_q;
    st_nxt.output_value_bit = st_nxt.output_value_bit ^ toggle;
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      st_r <= pin_pkg::STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pad_oe       = st_r.drive_en;
  assign pad_out      = st_r.drive_val;
  assign pad_pull_up  = st_r.pull_up;
  assign dir_rdata    = st_r.direction_bit;
  assign val_rdata    = st_r.output_value_bit;
  assign pin_rdata    = pin_sync_q;
  assign ext_int_flag = st_r.int_flag;
  assign sleep_clamp  = st_r.clamp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_s);

  a_clamp_deep_sleep: assert property (
    (sleep_mode == pin_pkg::SLEEP_IDLE) || (sleep_mode == pin_pkg::SLEEP_ACTIVE) |=> !st_r.clamp)
    else $error("Clamp set outside deep sleep.");
  a_clamp_standby_on: assert property (
    (sleep_mode == pin_pkg::SLEEP_STANDBY) |=> st_r.clamp)
    else $error("Clamp missing in standby.");
  a_reset_pads_off: assert property (
    disable iff (1'b0) !rst_n_s |-> (pad_oe == '0) && (pad_pull_up == '0))
    else $error("Pads driven or pulled during reset.");

  for (genvar g = 0; g < P; g++) begin : g_chk
    a_pull_up_select: assert property (
      1'b1 |=> pad_pull_up[g] == $past(ovr[g].pull_up_override_enable ?
        ovr[g].pull_up_override_value :
        (!st_r.direction_bit[g] && st_r.output_value_bit[g] && !global_pull_up_off)))
      else $error("Pull-up state wrong.");
    a_pull_up_off: assert property (
      global_pull_up_off && !ovr[g].pull_up_override_enable |=> !pad_pull_up[g])
      else $error("Pull-up on despite global disable.");
    a_driver_enable: assert property (
      1'b1 |=> pad_oe[g] == $past(ovr[g].direction_override_enable ?
        ovr[g].direction_override_value : st_r.direction_bit[g]))
      else $error("Driver enable wrong.");
    a_value_override: assert property (
      ovr[g].value_override_enable ##1 pad_oe[g]
      |-> pad_out[g] == $past(ovr[g].value_override_value))
      else $error("Override value not driven.");
    a_undriven_low: assert property (
      !pad_oe[g] |-> !pad_out[g])
      else $error("Value present with driver off.");
    a_toggle_invert: assert property (
      ovr[g].toggle_override_enable && !val_wr && !(pin_wr && pin_wdata[g])
      |=> val_rdata[g] != $past(val_rdata[g]))
      else $error("Toggle override did not invert.");
    a_pin_write_toggle: assert property (
      pin_wr && pin_wdata[g] && !val_wr && !ovr[g].toggle_override_enable
      |=> val_rdata[g] != $past(val_rdata[g]))
      else $error("Pin write did not toggle.");
    a_dir_write: assert property (
      dir_wr |=> dir_rdata[g] == $past(dir_wdata[g]))
      else $error("Direction write lost.");
    a_clamp_gate: assert property (
      st_r.clamp && !ext_int_en[g] && !ovr[g].input_enable_override_enable |=> !st_r.input_en[g])
      else $error("Clamp not applied to input.");
    a_input_override: assert property (
      ovr[g].input_enable_override_enable
      |=> st_r.input_en[g] == $past(ovr[g].input_enable_override_value))
      else $error("Input enable override ignored.");
    a_rise_flag: assert property (
      (ext_int_sense[g] == pin_pkg::SENSE_RISE) && !st_r.pin_prev[g] && pin_sync_q[g]
      |=> ext_int_flag[g])
      else $error("Rising edge flag not set.");
  end

endmodule // port_pin_override_logic
`default_nettype wire

/* sim/peripheral_model.sv */
// Model of the peripherals that own the alternate functions of one port.
// Assumes sys_clk and an active low asynchronous reset from the bench.
`timescale 1ns/100ps
`default_nettype none
module peripheral_model (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire pin_pkg::pin_override_t [7:0] cfg,
  input  wire logic                   [7:0] schmitt_output_tap,
  output var  pin_pkg::pin_override_t [7:0] ovr,
  output logic                        [7:0] tap_sync
);
  logic [7:0] tap_meta_r;
  // -----------------------------------------------------------
  // Overrides and own synchronizer
  // -----------------------------------------------------------
  // The tap is asynchronous, so it is resynchronized here before any use.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ovr        <= '0;
      tap_meta_r <= '0;
      tap_sync   <= '0;
    end else begin
      ovr        <= cfg;
      tap_meta_r <= schmitt_output_tap;
      tap_sync   <= tap_meta_r;
    end
  end
endmodule // peripheral_model
`default_nettype wire

/* sim/port_pin_override_logic_bench.sv */
// Self-checking bench for one port of the pin override logic.
// Assumes the peripheral model registers the overrides one cycle late.
`timescale 1ns/100ps
`default_nettype none
module port_pin_override_logic_bench;
  typedef struct {int due; int k; logic [7:0] v;} note_t;
  logic                          sys_clk, rstn, dir_wr, val_wr, pin_wr, gpo, clamp;
  logic                   [7:0] dir_wdata, val_wdata, pin_wdata, int_en, clr, pad_in;
  logic                   [7:0] pad_out, pad_oe, pad_pull_up, tap, tap_sync, flag;
  logic                   [7:0] dir_rdata, val_rdata, pin_rdata, d, v, t, oe, ov, pu;
  logic              [8:0][7:0] seen;
  pin_pkg::sleep_mode_t          mode;
  pin_pkg::int_sense_t    [7:0] sense;
  pin_pkg::pin_override_t [7:0] cfg, ovr;
  int                            cyc = 0, fails = 0, n_checks = 0;
  note_t                         q[$];
  string nm[9] = '{"pad_oe", "pad_out", "pad_pull_up", "dir_rdata", "val_rdata",
                   "pin_rdata", "ext_int_flag", "sleep_clamp", "tap_sync"};

  port_pin_override_logic u_port_pin_override_logic (.sys_clk, .rstn, .dir_wr, .dir_wdata,
    .val_wr, .val_wdata, .pin_wr, .pin_wdata, .global_pull_up_off(gpo), .sleep_mode(mode),
    .ext_int_en(int_en), .ext_int_sense(sense), .ext_int_flag_clr(clr), .ovr, .pad_in,
    .pad_out, .pad_oe, .pad_pull_up, .schmitt_output_tap(tap), .dir_rdata, .val_rdata,
    .pin_rdata, .ext_int_flag(flag), .sleep_clamp(clamp));
  peripheral_model u_peripheral_model (.sys_clk, .rstn, .cfg, .schmitt_output_tap(tap),
    .ovr, .tap_sync);

  // -----------------------------------------------------------
  // Clock, notes and checks
  // -----------------------------------------------------------
  assign seen = {tap_sync, {7'h00, clamp}, flag, pin_rdata, val_rdata, dir_rdata,
                 pad_pull_up, pad_out, pad_oe};
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  task automatic check(string name, logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Outputs are compared at the falling edge, when every update has landed.
  always @(negedge sys_clk) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      check(nm[q[0].k], seen[q[0].k], q[0].v);
      void'(q.pop_front());
    end
  end
  task automatic note(int k, logic [7:0] val, int lat);
    q.push_back('{cyc + lat, k, val});
  endtask
  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    stop_test();
  end

  // -----------------------------------------------------------
  // Stimulus
  // -----------------------------------------------------------
  initial begin
    {dir_wr, val_wr, pin_wr, gpo, dir_wdata, val_wdata, pin_wdata, int_en, clr} = '0;
    pad_in = 8'h00;
    rstn = 1'b0;
    mode = pin_pkg::SLEEP_ACTIVE;
    cfg = '0;
    for (int i = 0; i < 8; i++) sense[i] = pin_pkg::SENSE_RISE;
    sense[5] = pin_pkg::SENSE_ANY;
    sense[6] = pin_pkg::SENSE_FALL;
    sense[3] = pin_pkg::SENSE_LOW;
    void'($urandom(46));
    note(0, 8'h00, 2);
    note(2, 8'h00, 2);
    step(3);
    rstn = 1'b1;
    step(2);
    d = $urandom;
    v = $urandom;
    t = $urandom;
    dir_wr = 1'b1;
    dir_wdata = d;
    note(3, d, 1);
    step(1);
    dir_wr = 1'b0;
    val_wr = 1'b1;
    val_wdata = v;
    note(0, d, 1);
    note(4, v, 1);
    step(1);
    val_wr = 1'b0;
    pin_wr = 1'b1;
    pin_wdata = t;
    note(4, v ^ t, 1);
    step(1);
    pin_wr = 1'b0;
    v = v ^ t;
    step(2);
    note(1, d & v, 0);
    note(2, ~d & v, 0);
    gpo = 1'b1;
    note(2, 8'h00, 1);
    cfg[3].toggle_override_enable = 1'b1;
    step(1);
    cfg = '0;
    v = v ^ 8'h08;
    note(4, v, 1);
    step(2);
    for (int g = 0; g < 2; g++) begin
      gpo = g[0];
      for (int j = 0; j < 8; j++) begin
        for (int i = 0; i < 8; i++) begin
          cfg[i] = pin_pkg::pin_override_t'($urandom);
          cfg[i].toggle_override_enable = 1'b0;
          oe[i] = cfg[i].direction_override_enable ? cfg[i].direction_override_value : d[i];
          ov[i] = oe[i] & (cfg[i].value_override_enable ? cfg[i].value_override_value : v[i]);
          pu[i] = cfg[i].pull_up_override_enable ? cfg[i].pull_up_override_value
                                                 : (!d[i] && v[i] && !gpo);
        end
        note(0, oe, 2);
        note(1, ov, 2);
        note(2, pu, 2);
        step(1);
      end
      step(2);
    end
    cfg = '0;
    step(2);
    for (int j = 0; j < 4; j++) begin
      pad_in = $urandom;
      note(5, pad_in, 2);
      note(8, pad_in, 2);
      step(1);
    end
    for (int m = 0; m < 7; m++) begin
      mode = pin_pkg::sleep_mode_t'(m);
      note(7, {7'h00, m inside {3, 4, 5}}, 1);
      step(1);
    end
    mode = pin_pkg::SLEEP_ACTIVE;
    pad_in = 8'hFF;
    step(6);
    clr = 8'hFF;
    step(1);
    clr = 8'h00;
    note(6, 8'h00, 0);
    int_en = 8'h07;
    cfg[7].input_enable_override_enable = 1'b1;
    cfg[7].input_enable_override_value = 1'b1;
    mode = pin_pkg::SLEEP_POWER_DOWN;
    step(6);
    note(5, 8'h87, 0);
    note(6, 8'h68, 0);
    mode = pin_pkg::SLEEP_ACTIVE;
    step(6);
    note(6, 8'h78, 0);
    step(2);
    rstn = 1'b0;
    note(0, 8'h00, 0);
    note(2, 8'h00, 0);
    note(6, 8'h00, 0);
    step(3);
    rstn = 1'b1;
    step(2);
    if (q.size() != 0) fails++;
    stop_test();
  end
endmodule // port_pin_override_logic_bench
`default_nettype wire
